// >>> design/logic_cell_cfg.svh
// Constants for one programmable logic cell with an AXI4-Lite configuration port.
// Assumes a single 10 MHz clock and a synchronous, active-high reset.
// Functional notes
// R1: Four-input lookup table realises any Boolean function of its four inputs.
// R2: Cell register works as D, T, JK or SR flip-flop.
// R3: Register has data, clock, clock enable and clear inputs.
// R4: Register clock and clear come from global network, pin or internal logic.
// R5: Clock enable comes from a pin or internal logic, never the global network.
// R6: Combinational use routes the table result around the register to outputs.
// R7: Three general outputs serve local, row and column routing.
// R8: Each general output independently carries table result or register output.
// R9: Two outputs feed row/column and direct link; one feeds local only.
// R10: Packed use lets table and register serve unrelated functions on separate outputs.
// R11: Packed register ignores the group-wide synchronous load.
// R12: Feedback use routes the register output into the cell's own table.
// R13: Registered and unregistered table result can be presented together.
// R14: A dedicated cascade output feeds the adjacent cell register.
// R15: Cascaded registers form a shift register while the table does other work.
// R16: Clock, clears, load and enable come from group-wide shared control lines; the code clocks from clk_i, a pin or internal logic, never a group line.
// R17: With the group enable low the register holds its value.
// R18: Enabled active-low chip-wide reset clears the register over everything else.
// R19: Async clear beats sync clear, which beats sync load, which beats data.
// R20: After a clear the register holds zero until the next enabled edge.
`ifndef LOGIC_CELL_CFG_SVH
`define LOGIC_CELL_CFG_SVH
`define LC_ADDR_W 4
`define LC_DATA_W 32
`define LC_LUT_W 16
`define LC_CFG_W 14
`define LC_OFF_LUT 4'h0
`define LC_OFF_CFG 4'h4
`define LC_OFF_STAT 4'h8
`define LC_LUT_RST 16'h0000
`define LC_CFG_RST 14'h0000
`define LC_RESP_OK 2'h0
`define LC_RESP_ERR 2'h2
`define LC_AUX_IDX 3
`define LC_OUT_LOCAL 0
`define LC_OUT_ROW 1
`define LC_OUT_COL 2
`endif

// >>> design/logic_cell_pkg.sv
// Types shared by the logic cell and its bench.
// Assumes logic_cell_cfg.svh supplies all numeric constants.
package logic_cell_pkg;
   typedef enum logic [1:0] {SRC_GLOBAL = 2'h0, SRC_PIN = 2'h1, SRC_INTERNAL = 2'h2} src_e;
   typedef enum logic [1:0] {FF_D = 2'h0, FF_T = 2'h1, FF_JK = 2'h2, FF_SR = 2'h3} ff_type_e;
   typedef enum logic [1:0] {DSEL_LUT = 2'h0, DSEL_DIRECT = 2'h1, DSEL_CHAIN = 2'h2} dsel_e;
   typedef enum logic [1:0] {WR_IDLE = 2'h1, WR_RESP = 2'h2} wr_state_e;
   // Configuration word, low bits of the config register
   typedef struct packed {
      logic chip_rst_en;
      src_e clk_src;
      src_e clr_src;
      logic ena_internal;
      ff_type_e ff_type;
      dsel_e dsel;
      logic feedback;
      logic [2:0] osel;
   } cfg_s;
   // Group-wide control lines shared by all cells of a group
   typedef struct packed {
      logic ena;
      logic aclr;
      logic sclr;
      logic sload;
      logic sload_data;
   } grp_ctrl_s;
endpackage

// >>> design/logic_cell.sv
// One programmable logic cell: lookup table, configurable register, output routing.
// Assumes every input is synchronous to clk_i; AXI4-Lite master per its specification.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "logic_cell_cfg.svh"
module logic_cell (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] data_i,
   input wire logic pin_clk_i,
   input wire logic int_clk_i,
   input wire logic pin_clr_i,
   input wire logic int_clr_i,
   input wire logic pin_ena_i,
   input wire logic int_ena_i,
   input wire logic_cell_pkg::grp_ctrl_s grp_i,
   input wire logic chain_i,
   input wire logic chip_wide_reset_n_i,
   output logic local_o,
   output logic row_o,
   output logic col_o,
   output logic cascade_o,
   input wire logic [`LC_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [`LC_DATA_W-1:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [`LC_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [`LC_DATA_W-1:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);

   logic [`LC_LUT_W-1:0] lut_mask_ff;
   logic_cell_pkg::cfg_s cfg_ff;
   logic q_ff;
   logic clk_prev_ff;
   logic [3:0] lut_in;
   logic lut_out;
   logic clk_lvl;
   logic tick;
   logic ena_eff;
   logic clr_lvl;
   logic chip_rst;
   logic ff_d;
   logic nxt_q;
   logic advance;
   logic packed_use;

   // Picks one of three sources; an unused code falls back to the global line
   function automatic logic sel_src(input logic_cell_pkg::src_e src, input logic glob,
                                    input logic pin, input logic intl);
      case (src)
         logic_cell_pkg::SRC_PIN: sel_src = pin;
         logic_cell_pkg::SRC_INTERNAL: sel_src = intl;
         default: sel_src = glob;
      endcase
   endfunction

   // Merges a bus word into a register under byte strobes
   function automatic logic [`LC_DATA_W-1:0] merge_strb(input logic [`LC_DATA_W-1:0] old,
                                                         input logic [`LC_DATA_W-1:0] wdat,
                                                         input logic [3:0] strb);
      logic [`LC_DATA_W-1:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wdat[i*8 +: 8];
         end
      end
      merge_strb = res;
   endfunction

   // Table inputs; feedback swaps the top input for the register
   assign lut_in = {cfg_ff.feedback ? q_ff : data_i[`LC_AUX_IDX], data_i[`LC_AUX_IDX-1:0]}; // R12
   assign lut_out = lut_mask_ff[lut_in]; // R1

   // Clock and clear sources; global clock means every rising edge of clk_i
   assign clk_lvl = sel_src(cfg_ff.clk_src, 1'h0, pin_clk_i, int_clk_i); // R4
   assign tick = (cfg_ff.clk_src == logic_cell_pkg::SRC_GLOBAL) | (clk_lvl & ~clk_prev_ff); // R3
   assign clr_lvl = sel_src(cfg_ff.clr_src, grp_i.aclr, pin_clr_i, int_clr_i); // R4
   // Global network is not a choice for the enable
   assign ena_eff = grp_i.ena & (cfg_ff.ena_internal ? int_ena_i : pin_ena_i); // R5 R16
   assign chip_rst = cfg_ff.chip_rst_en & ~chip_wide_reset_n_i;
   assign advance = tick & ena_eff;
   // Any non-table data source frees the table, so the cell is packed
   assign packed_use = (cfg_ff.dsel != logic_cell_pkg::DSEL_LUT); // R10

   // Register data source
   always_comb begin
      case (cfg_ff.dsel)
         logic_cell_pkg::DSEL_DIRECT: ff_d = data_i[`LC_AUX_IDX];
         logic_cell_pkg::DSEL_CHAIN: ff_d = chain_i; // R15
         default: ff_d = lut_out;
      endcase
   end

   // Flip-flop personality; second input of JK and SR is the top data pin
   always_comb begin
      case (cfg_ff.ff_type) // R2
         logic_cell_pkg::FF_T: nxt_q = q_ff ^ ff_d;
         logic_cell_pkg::FF_JK: nxt_q = (ff_d & ~q_ff) | (~data_i[`LC_AUX_IDX] & q_ff);
         logic_cell_pkg::FF_SR: nxt_q = ~data_i[`LC_AUX_IDX] & (ff_d | q_ff);
         default: nxt_q = ff_d;
      endcase
   end

   // Previous clock level for edge detection on pin or internal sources
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_prev_ff <= 1'h0;
      end else begin
         clk_prev_ff <= clk_lvl;
      end
   end

   // Cell register; clear acts on the next clk_i edge, without waiting for a cell clock edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= 1'h0;
      end else if (chip_rst) begin
         q_ff <= 1'h0; // R18
      end else if (clr_lvl) begin
         q_ff <= 1'h0; // R19 R20
      end else if (advance) begin // R17
         if (grp_i.sclr) begin
            q_ff <= 1'h0; // R19
         end else if (grp_i.sload && !packed_use) begin
            q_ff <= grp_i.sload_data; // R11 R16
         end else begin
            q_ff <= nxt_q;
         end
      end
   end

   // Output routing; osel bit high picks the register, low the table
   assign local_o = cfg_ff.osel[`LC_OUT_LOCAL] ? q_ff : lut_out; // R6 R8 R9
   assign row_o = cfg_ff.osel[`LC_OUT_ROW] ? q_ff : lut_out; // R7 R8 R13
   assign col_o = cfg_ff.osel[`LC_OUT_COL] ? q_ff : lut_out; // R7 R9
   assign cascade_o = q_ff; // R14

   // Bus write side
   logic_cell_pkg::wr_state_e wr_state_ff;
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [`LC_ADDR_W-1:0] awaddr_ff;
   logic [`LC_DATA_W-1:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff;
   logic wr_go;
   logic wr_hit;

   assign s_axi_awready_o = ~aw_hold_ff & (wr_state_ff == logic_cell_pkg::WR_IDLE);
   assign s_axi_wready_o = ~w_hold_ff & (wr_state_ff == logic_cell_pkg::WR_IDLE);
   assign wr_go = aw_hold_ff & w_hold_ff & (wr_state_ff == logic_cell_pkg::WR_IDLE);
   assign wr_hit = (awaddr_ff == `LC_OFF_LUT) | (awaddr_ff == `LC_OFF_CFG);
   assign s_axi_bvalid_o = (wr_state_ff == logic_cell_pkg::WR_RESP);
   assign s_axi_bresp_o = bresp_ff;

   // Address and data are caught in either order and held until the write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_hold_ff <= 1'h0;
         w_hold_ff <= 1'h0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_ff <= 1'h1;
            awaddr_ff <= s_axi_awaddr_i;
         end else if (wr_go) begin
            aw_hold_ff <= 1'h0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_ff <= 1'h1;
            wdata_ff <= s_axi_wdata_i;
            wstrb_ff <= s_axi_wstrb_i;
         end else if (wr_go) begin
            w_hold_ff <= 1'h0;
         end
      end
   end

   // Write response state; no new write is taken while a response waits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_state_ff <= logic_cell_pkg::WR_IDLE;
         bresp_ff <= `LC_RESP_OK;
      end else begin
         case (wr_state_ff)
            logic_cell_pkg::WR_IDLE: begin
               if (wr_go) begin
                  wr_state_ff <= logic_cell_pkg::WR_RESP;
                  bresp_ff <= wr_hit ? `LC_RESP_OK : `LC_RESP_ERR;
               end
            end
            logic_cell_pkg::WR_RESP: begin
               if (s_axi_bready_i) begin
                  wr_state_ff <= logic_cell_pkg::WR_IDLE;
               end
            end
            default: wr_state_ff <= logic_cell_pkg::WR_IDLE;
         endcase
      end
   end

   // Strobe-merged words; a function result cannot be part-selected directly
   logic [`LC_DATA_W-1:0] lut_merged;
   logic [`LC_DATA_W-1:0] cfg_merged;
   assign lut_merged = merge_strb(`LC_DATA_W'(lut_mask_ff), wdata_ff, wstrb_ff);
   assign cfg_merged = merge_strb(`LC_DATA_W'(cfg_ff), wdata_ff, wstrb_ff);

   // Table mask and configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lut_mask_ff <= `LC_LUT_RST;
         cfg_ff <= logic_cell_pkg::cfg_s'(`LC_CFG_RST);
      end else if (wr_go && awaddr_ff == `LC_OFF_LUT) begin
         lut_mask_ff <= lut_merged[`LC_LUT_W-1:0];
      end else if (wr_go && awaddr_ff == `LC_OFF_CFG) begin
         cfg_ff <= logic_cell_pkg::cfg_s'(cfg_merged[`LC_CFG_W-1:0]);
      end
   end

   // Bus read side; status shows the live cell state
   logic rvalid_ff;
   logic [`LC_DATA_W-1:0] rdata_ff;
   logic [1:0] rresp_ff;

   assign s_axi_arready_o = ~rvalid_ff;
   assign s_axi_rvalid_o = rvalid_ff;
   assign s_axi_rdata_o = rdata_ff;
   assign s_axi_rresp_o = rresp_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rvalid_ff <= 1'h0;
         rdata_ff <= '0;
         rresp_ff <= `LC_RESP_OK;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_ff <= 1'h1;
         rresp_ff <= `LC_RESP_OK;
         case (s_axi_araddr_i)
            `LC_OFF_LUT: rdata_ff <= `LC_DATA_W'(lut_mask_ff);
            `LC_OFF_CFG: rdata_ff <= `LC_DATA_W'(cfg_ff);
            `LC_OFF_STAT: rdata_ff <= `LC_DATA_W'({clr_lvl, ena_eff, lut_out, q_ff});
            default: begin
               rdata_ff <= '0;
               rresp_ff <= `LC_RESP_ERR;
            end
         endcase
      end else if (s_axi_rready_i) begin
         rvalid_ff <= 1'h0;
      end
   end

   // Checks on the cell behaviour, and one on the write response
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_chip_reset_wins: assert property (chip_rst |=> !q_ff) // R18
      else $error("chip reset did not clear register");
   a_clear_zero: assert property (clr_lvl && !chip_rst |=> !q_ff) // R19
      else $error("clear did not clear register");
   a_zero_holds: assert property (!q_ff && !advance && !chip_rst |=> !q_ff) // R20
      else $error("register left zero without an enabled edge");
   a_hold_disabled: assert property (!ena_eff && !clr_lvl && !chip_rst |=> $stable(q_ff)) // R17
      else $error("register changed with enable low");
   a_sclr_over_load: assert property (advance && grp_i.sclr && grp_i.sload |=> !q_ff) // R19
      else $error("sync clear lost to sync load");
   a_packed_no_load: assert property (advance && !clr_lvl && !chip_rst && !grp_i.sclr
      && packed_use && cfg_ff.ff_type == logic_cell_pkg::FF_D |=> q_ff == $past(ff_d)) // R11
      else $error("packed register took sync load");
   a_chain_shift: assert property (advance && !clr_lvl && !chip_rst && !grp_i.sclr
      && cfg_ff.dsel == logic_cell_pkg::DSEL_CHAIN && cfg_ff.ff_type == logic_cell_pkg::FF_D
      |=> cascade_o == $past(chain_i)) // R15
      else $error("cascade did not shift");
   a_toggle_flip: assert property (advance && !clr_lvl && !chip_rst && !grp_i.sclr
      && !(grp_i.sload && !packed_use) && cfg_ff.ff_type == logic_cell_pkg::FF_T && ff_d
      |=> q_ff != $past(q_ff)) // R2
      else $error("toggle register did not flip");
   a_bypass_route: assert property (!cfg_ff.osel[`LC_OUT_ROW] && !cfg_ff.feedback
      |-> row_o == lut_mask_ff[data_i]) // R6
      else $error("row output not the table result");
   a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |=> ##1 s_axi_bvalid_o)
      else $error("write response missing");

   // Register personality and sync load checks
   a_d_capture: assert property (advance && !clr_lvl && !chip_rst && !grp_i.sclr
      && !(grp_i.sload && !packed_use) && cfg_ff.ff_type == logic_cell_pkg::FF_D
      |=> q_ff == $past(ff_d)) // R2 R3
      else $error("D register did not take its data");
   a_jk_hold: assert property (advance && !clr_lvl && !chip_rst && !grp_i.sclr
      && !(grp_i.sload && !packed_use) && cfg_ff.ff_type == logic_cell_pkg::FF_JK
      && !ff_d && !data_i[`LC_AUX_IDX] |=> $stable(q_ff)) // R2
      else $error("JK register moved with both inputs low");
   a_sr_reset: assert property (advance && !clr_lvl && !chip_rst && !grp_i.sclr
      && !(grp_i.sload && !packed_use) && cfg_ff.ff_type == logic_cell_pkg::FF_SR
      && data_i[`LC_AUX_IDX] |=> !q_ff) // R2
      else $error("SR register ignored its reset input");
   a_load_takes: assert property (advance && !clr_lvl && !chip_rst && !grp_i.sclr
      && grp_i.sload && !packed_use |=> q_ff == $past(grp_i.sload_data)) // R16
      else $error("sync load not taken");
   // Clock and enable source checks
   a_pin_edge_only: assert property (cfg_ff.clk_src == logic_cell_pkg::SRC_PIN
      && !(pin_clk_i && !clk_prev_ff) |-> !advance) // R4
      else $error("register advanced without a pin clock edge");
   a_enable_pin: assert property (!cfg_ff.ena_internal && !pin_ena_i |-> !ena_eff) // R5
      else $error("enable active with pin enable low");

   // Routing checks
   a_local_route: assert property (cfg_ff.osel[`LC_OUT_LOCAL] |-> local_o == q_ff) // R8 R9
      else $error("local output not the register");
   a_col_route: assert property (!cfg_ff.osel[`LC_OUT_COL] |-> col_o == lut_out) // R7 R8
      else $error("column output not the table result");
   a_row_reg: assert property (cfg_ff.osel[`LC_OUT_ROW] |-> row_o == q_ff) // R13
      else $error("row output not the register");

   // Bus handshake checks
   a_busy_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while a response waits");
   a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read response missing");
   a_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped before handshake");
   a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped before handshake");

   c_packed_use: cover property (packed_use && local_o != row_o);
   c_chain_run: cover property ((cfg_ff.dsel == logic_cell_pkg::DSEL_CHAIN && advance) [*3]);
   c_clear_then_edge: cover property (clr_lvl ##1 !clr_lvl && advance ##1 q_ff);
   c_read_status: cover property (s_axi_arvalid_i && s_axi_arready_o
      && s_axi_araddr_i == `LC_OFF_STAT);

endmodule

// >>> dv/neighbour_cell.sv
// Model of the preceding cell register feeding this cell's cascade input.
// Assumes the same clock and synchronous active-high reset as the cell.
`timescale 1ns/100ps
module neighbour_cell (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic shift_i,
   output logic q_o
);
   // One stage of the shift chain; cleared so the cell never sees an unknown
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= 1'b0;
      end else begin
         q_o <= shift_i;
      end
   end
endmodule

// >>> dv/tb.sv
// Self-checking bench for one logic cell: bus tasks, cell scenarios, verdict.
// Assumes design package, header and the neighbour_cell model compile first.
`timescale 1ns/100ps
`include "logic_cell_cfg.svh"
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] data_i = 4'h0;
   logic pin_clk = 1'b0;
   logic pin_ena = 1'b0;
   logic chip_n = 1'b1;
   logic_cell_pkg::grp_ctrl_s grp = 5'h10;
   logic shift = 1'b0;
   logic chain, local_o, row_o, col_o, cascade_o;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs_q;
   logic [31:0] rdata, rd_q;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;

   // 100 ns period
   always #50 clk_i = ~clk_i;

   logic_cell uut (.clk_i(clk_i), .rst_i(rst_i), .data_i(data_i), .pin_clk_i(pin_clk), .int_clk_i(1'b0),
      .pin_clr_i(1'b0), .int_clr_i(1'b0), .pin_ena_i(pin_ena), .int_ena_i(1'b0), .grp_i(grp),
      .chain_i(chain), .chip_wide_reset_n_i(chip_n), .local_o(local_o), .row_o(row_o), .col_o(col_o),
      .cascade_o(cascade_o), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
   neighbour_cell prev_cell (.clk_i(clk_i), .rst_i(rst_i), .shift_i(shift), .q_o(chain));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Bus write: both channels offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      logic aw_now;
      logic w_now;
      logic [1:0] resp;
      @(posedge clk_i);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      aw = 1'b1;
      w = 1'b1;
      // Readies are settled mid-cycle; the next edge is the one that takes
      while (aw || w) begin
         @(negedge clk_i);
         aw_now = aw && (awready === 1'b1);
         w_now = w && (wready === 1'b1);
         @(posedge clk_i);
         if (aw_now) begin
            awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (w_now) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
      end
      @(negedge clk_i);
      while (bvalid !== 1'b1) @(negedge clk_i);
      resp = bresp;
      @(posedge clk_i);
      bready <= 1'b0;
      chk(resp, er);
   endtask

   // Bus read; result left in rd_q and rs_q
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      {araddr, arvalid, rready} <= {a, 2'h3};
      @(negedge clk_i);
      while (arready !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
      arvalid <= 1'b0;
      @(negedge clk_i);
      while (rvalid !== 1'b1) @(negedge clk_i);
      {rd_q, rs_q} = {rdata, rresp};
      @(posedge clk_i);
      rready <= 1'b0;
   endtask

   // Enable is dropped while the config changes so q cannot move mid-write
   task automatic setcfg(input logic re, input logic [1:0] cs, input logic [1:0] ft, input logic [1:0] ds,
      input logic fb, input logic [2:0] os);
      @(posedge clk_i) pin_ena <= 1'b0;
      wr(`LC_OFF_CFG, {18'h0, re, cs, 3'h0, ft, ds, fb, os}, `LC_RESP_OK);
      pin_ena <= 1'b1;
   endtask

   // Drive table inputs; check q produced by the previous sample
   task automatic st(input logic [3:0] d, input logic e);
      @(posedge clk_i) data_i <= d;
      @(negedge clk_i);
      chk(cascade_o, e);
   endtask

   // Drive table inputs; check the three general outputs mid-cycle
   task automatic ob(input logic [3:0] d, input logic [2:0] e);
      @(posedge clk_i) data_i <= d;
      @(negedge clk_i);
      chk({local_o, row_o, col_o}, e);
   endtask

   // One sample edge after a drive, then check q
   task automatic hc(input logic e);
      @(posedge clk_i);
      @(negedge clk_i);
      chk(cascade_o, e);
   endtask

   task automatic t_reset;
      chk({local_o, row_o, col_o, cascade_o}, 4'h0);
      rd(`LC_OFF_LUT);
      chk(rd_q, `LC_LUT_RST);
      rd(`LC_OFF_CFG);
      chk(rd_q, `LC_CFG_RST);
      rd(4'hC);
      chk(rs_q, `LC_RESP_ERR);
      chk(rd_q, 32'h0);
      wr(`LC_OFF_STAT, 32'h1, `LC_RESP_ERR);
      wr(4'hC, 32'h1, `LC_RESP_ERR);
   endtask

   // Upper word bits are written as ones and must read back zero
   task automatic t_lut;
      logic [15:0] m;
      for (int k = 0; k < 2; k++) begin
         m = k ? 16'hA5C3 : 16'h6996;
         wr(`LC_OFF_LUT, {16'hFFFF, m}, `LC_RESP_OK);
         rd(`LC_OFF_LUT);
         chk(rd_q, {16'h0, m});
         for (int i = 0; i < 16; i++) ob(i[3:0], {3{m[i]}});
      end
   endtask

   task automatic t_route;
      wr(`LC_OFF_LUT, 32'h8000, `LC_RESP_OK);
      setcfg(1'b0, logic_cell_pkg::SRC_GLOBAL, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_DIRECT, 1'b0, 3'h6);
      ob(4'hF, 3'h7);
      ob(4'h7, 3'h3);
      ob(4'h7, 3'h0);
      setcfg(1'b0, logic_cell_pkg::SRC_GLOBAL, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_LUT, 1'b0, 3'h2);
      ob(4'hF, 3'h5);
      ob(4'h0, 3'h2);
   endtask

   // Group word order is ena, aclr, sclr, sload, sload_data
   task automatic t_ctrl;
      wr(`LC_OFF_LUT, 32'hAAAA, `LC_RESP_OK);
      setcfg(1'b0, logic_cell_pkg::SRC_GLOBAL, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_LUT, 1'b0, 3'h7);
      @(posedge clk_i) data_i <= 4'h1;
      hc(1'b1);
      @(posedge clk_i) {pin_ena, data_i} <= 5'h00;
      hc(1'b1);
      hc(1'b1);
      @(posedge clk_i) {pin_ena, grp} <= 6'h20;
      hc(1'b1);
      @(posedge clk_i) grp <= 5'h17;
      hc(1'b0);
      @(posedge clk_i) grp <= 5'h13;
      hc(1'b1);
      @(posedge clk_i) grp <= 5'h0B;
      hc(1'b0);
      @(posedge clk_i) grp <= 5'h03;
      hc(1'b0);
      @(posedge clk_i) grp <= 5'h13;
      hc(1'b1);
      setcfg(1'b0, logic_cell_pkg::SRC_GLOBAL, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_DIRECT, 1'b0, 3'h7);
      hc(1'b0);
      @(posedge clk_i) grp <= 5'h10;
   endtask

   task automatic t_chip_pin;
      setcfg(1'b1, logic_cell_pkg::SRC_GLOBAL, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_LUT, 1'b0, 3'h7);
      @(posedge clk_i) data_i <= 4'h1;
      hc(1'b1);
      rd(`LC_OFF_STAT);
      chk(rd_q[0], 1'b1);
      @(posedge clk_i) {chip_n, grp} <= 6'h13;
      hc(1'b0);
      @(posedge clk_i) {chip_n, grp} <= 6'h30;
      hc(1'b1);
      setcfg(1'b0, logic_cell_pkg::SRC_PIN, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_LUT, 1'b0, 3'h7);
      @(posedge clk_i) data_i <= 4'h0;
      hc(1'b1);
      @(posedge clk_i) pin_clk <= 1'b1;
      @(posedge clk_i);
      hc(1'b0);
      @(posedge clk_i) data_i <= 4'h1;
      hc(1'b0);
      @(posedge clk_i) {pin_clk, data_i} <= 5'h00;
   endtask

   // Four steps per type; each check sees the result of the step before
   task automatic seq(input logic [1:0] ft, input logic [15:0] ds, input logic [3:0] es);
      setcfg(1'b0, logic_cell_pkg::SRC_GLOBAL, ft, logic_cell_pkg::DSEL_LUT, 1'b0, 3'h7);
      for (int i = 3; i >= 0; i--) st(ds[i*4 +: 4], es[i]);
   endtask

   task automatic t_fb_chain;
      logic prev;
      logic [11:0] pat;
      pat = 12'h2D3;
      wr(`LC_OFF_LUT, 32'h00FF, `LC_RESP_OK);
      setcfg(1'b0, logic_cell_pkg::SRC_GLOBAL, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_LUT, 1'b1, 3'h7);
      st(4'h8, 1'b1);
      st(4'h8, 1'b0);
      st(4'h8, 1'b1);
      setcfg(1'b0, logic_cell_pkg::SRC_GLOBAL, logic_cell_pkg::FF_D, logic_cell_pkg::DSEL_CHAIN, 1'b0, 3'h6);
      @(negedge clk_i) prev = chain;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_i) {shift, data_i} <= {pat[i], i[3:0]};
         @(negedge clk_i);
         chk(cascade_o, prev);
         chk(local_o, i < 8);
         prev = chain;
      end
   endtask

   // Verdict and end of run
   task automatic give_verdict;
      if (mismatches == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cycle ceiling well above the few hundred the scenarios need
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict;
      end
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      t_reset;
      t_lut;
      t_route;
      t_ctrl;
      t_chip_pin;
      seq(logic_cell_pkg::FF_T, 16'h1100, 4'h4);
      seq(logic_cell_pkg::FF_JK, 16'h1890, 4'h5);
      seq(logic_cell_pkg::FF_SR, 16'h9108, 4'hB);
      t_fb_chain;
      give_verdict;
   end
endmodule
